// File: gpib_event_mask_dma_mode.v
// Event disarm, sticky event status, interrupt and DMA request control
// Contract
// - Disarm word 16 bits, bits 15-9 zero
// - Bit 8 disarms addressing state change
// - Bit 7 disarms becoming active controller
// - Bit 6 disarms becoming peripheral
// - Bit 5 disarms bus trigger as peripheral
// - Bit 4 disarms own service request set
// - Bit 3 disarms bus clear as peripheral
// - Bit 2 disarms listener addressed
// - Bit 1 disarms talker addressed
// - Bit 0 disarms becoming unaddressed
// - DMA mode word; default single, no autoinit
// - Single mode: one byte per request
// - Demand mode: hold request while data ready
// - Operations address board zero to three
// - Completion code zero means success
// - Autoinit reloads count and repeats transfer
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "gpib_event_mask_dma_mode_defs.vh"

module gpib_event_mask_dma_mode #(
  parameter [1:0] BOARD_ID = 2'h0,
  parameter COUNT_W = 16
) (
  input wire mclk,
  input wire rst_n,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [8:0] gpibEvent,
  input wire byteReady,
  input wire byteTaken,
  output reg dmaReq,
  output reg dmaDone,
  output wire lightPenIrq
);

  // ==========================================================
  // Event pins: two-stage synchroniser and rising edge detect
  reg [8:0] evMeta;
  reg [8:0] evSync;
  reg [8:0] evLast;
  wire [8:0] evPulse;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evMeta <= 9'h000;
      evSync <= 9'h000;
      evLast <= 9'h000;
    end
    else
    begin
      evMeta <= gpibEvent;
      evSync <= evMeta;
      evLast <= evSync;
    end
  end

  assign evPulse = evSync & ~evLast;

  // ==========================================================
  // Registers
  reg [1:0] boardSelect;
  reg [8:0] disarm;
  reg addrStateChangeMask;
  reg oneBytePerRequest;
  reg holdBusWhileRequested;
  reg autoInit;
  reg [8:0] status;
  reg [7:0] resultCode;
  reg [COUNT_W-1:0] dmaCount;
  reg [COUNT_W-1:0] dmaLeft;
  reg dmaRun;

  // ==========================================================
  // AXI4-Lite write channel
  reg awHeld;
  reg wHeld;
  reg [5:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  wire doWrite;
  wire [31:0] wMask;
  wire [31:0] wVal;
  wire boardOk;
  wire writeMapped;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
  assign wVal = wData & wMask;
  assign boardOk = (boardSelect == BOARD_ID);
  assign writeMapped = (awAddr == `REG_BOARD) || (awAddr == `REG_DISARM) ||
    (awAddr == `REG_DMA_MODE) || (awAddr == `REG_STATUS) ||
    (awAddr == `REG_DMA_COUNT);

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 6'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[5:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writeMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Configuration writes with completion code
  wire wrBoard;
  wire wrDisarm;
  wire wrMode;
  wire wrStatus;
  wire wrCount;
  wire [15:0] modeWord;
  wire bothModes;

  assign wrBoard = doWrite && (awAddr == `REG_BOARD);
  assign wrDisarm = doWrite && (awAddr == `REG_DISARM);
  assign wrMode = doWrite && (awAddr == `REG_DMA_MODE);
  assign wrStatus = doWrite && (awAddr == `REG_STATUS);
  assign wrCount = doWrite && (awAddr == `REG_DMA_COUNT);
  assign modeWord = wVal[15:0];
  assign bothModes = modeWord[`DMA_SINGLE_BIT] && modeWord[`DMA_DEMAND_BIT];

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boardSelect <= 2'h0;
      disarm <= 9'h000;
      oneBytePerRequest <= 1'b1;
      holdBusWhileRequested <= 1'b0;
      autoInit <= 1'b0;
      resultCode <= `RES_OK;
    end
    else
    begin
      if (wrBoard)
      begin
        boardSelect <= wVal[1:0];
        resultCode <= `RES_OK;
      end
      if (wrDisarm)
      begin
        if (!boardOk)
          resultCode <= `RES_BAD_BOARD;
        else if ((wVal[15:0] & `EV_RESERVED_MASK) != 16'h0000)
          resultCode <= `RES_RESERVED_SET;
        else
        begin
          disarm <= wVal[8:0];
          resultCode <= `RES_OK;
        end
      end
      if (wrMode)
      begin
        if (!boardOk)
          resultCode <= `RES_BAD_BOARD;
        else if ((modeWord & `DMA_MODE_RESERVED_MASK) != 16'h0000)
          resultCode <= `RES_RESERVED_SET;
        else if (bothModes)
          resultCode <= `RES_BOTH_MODES;
        else
        begin
          // No mode given falls back to single mode
          oneBytePerRequest <= !modeWord[`DMA_DEMAND_BIT];
          holdBusWhileRequested <= modeWord[`DMA_DEMAND_BIT];
          autoInit <= modeWord[`DMA_AUTO_BIT];
          resultCode <= `RES_OK;
        end
      end
      if (wrCount && !boardOk)
        resultCode <= `RES_BAD_BOARD;
      else if (wrCount)
        resultCode <= `RES_OK;
    end
  end

  // ==========================================================
  // Sticky event status, write one to clear, set wins
  wire [8:0] armed;
  wire [8:0] clearBits;

  assign armed = ~{addrStateChangeMask, disarm[7:0]};
  assign clearBits = wrStatus ? wVal[8:0] : 9'h000;

  genvar gi;
  generate
    for (gi = 0; gi < `EV_COUNT; gi = gi + 1)
    begin : g_status
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          status[gi] <= 1'b0;
        else if (evPulse[gi])
          status[gi] <= 1'b1;
        else if (clearBits[gi])
          status[gi] <= 1'b0;
      end
    end
  endgenerate

  // Disarmed events stay off the interrupt until their disarm bit is cleared
  assign lightPenIrq = |(status & armed);

  always @*
  begin
    addrStateChangeMask = disarm[`EV_ADDR_CHANGE];
  end

  // ==========================================================
  // DMA request control
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ = 2'h1;
  localparam ST_GAP = 2'h2;
  localparam integer GAP_COUNT = `SINGLE_GAP_CYCLES;
  localparam [1:0] GAP_CYCLES = GAP_COUNT[1:0];

  reg [1:0] dmaState;
  reg [1:0] gapCount;
  wire countLast;

  assign countLast = (dmaLeft == {{(COUNT_W-1){1'b0}}, 1'b1});

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dmaState <= ST_IDLE;
      dmaReq <= 1'b0;
      dmaDone <= 1'b0;
      dmaRun <= 1'b0;
      dmaCount <= {COUNT_W{1'b0}};
      dmaLeft <= {COUNT_W{1'b0}};
      gapCount <= 2'h0;
    end
    else
    begin
      dmaDone <= 1'b0;
      if (wrCount && boardOk)
      begin
        dmaCount <= wVal[COUNT_W-1:0];
        dmaLeft <= wVal[COUNT_W-1:0];
        dmaRun <= (wVal[COUNT_W-1:0] != {COUNT_W{1'b0}});
        dmaReq <= 1'b0;
        dmaState <= ST_IDLE;
      end
      else
      begin
        case (dmaState)
          ST_IDLE:
          begin
            if (dmaRun && byteReady)
            begin
              dmaReq <= 1'b1;
              dmaState <= ST_REQ;
            end
          end
          ST_REQ:
          begin
            if (byteTaken)
            begin
              if (countLast)
              begin
                dmaDone <= 1'b1;
                dmaRun <= autoInit;
                dmaLeft <= autoInit ? dmaCount : {COUNT_W{1'b0}};
              end
              else
                dmaLeft <= dmaLeft - {{(COUNT_W-1){1'b0}}, 1'b1};
            end
            if (oneBytePerRequest)
            begin
              if (byteTaken)
              begin
                dmaReq <= 1'b0;
                gapCount <= GAP_CYCLES;
                dmaState <= ST_GAP;
              end
            end
            else if ((byteTaken && countLast && !autoInit) || !byteReady)
            begin
              dmaReq <= 1'b0;
              gapCount <= GAP_CYCLES;
              dmaState <= ST_GAP;
            end
          end
          ST_GAP:
          begin
            // Request stays low long enough to hand the bus back
            if (gapCount <= 2'h1)
              dmaState <= ST_IDLE;
            else
              gapCount <= gapCount - 2'h1;
          end
          default:
          begin
            dmaReq <= 1'b0;
            dmaState <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  reg [31:0] readMux;
  reg readMapped;

  assign s_axi_arready = !s_axi_rvalid;

  always @*
  begin
    readMux = 32'h00000000;
    readMapped = 1'b1;
    case ({s_axi_araddr[5:2], 2'h0})
      `REG_BOARD: readMux = {30'h00000000, boardSelect};
      `REG_DISARM: readMux = {23'h000000, disarm};
      `REG_DMA_MODE: readMux = {29'h00000000, oneBytePerRequest, holdBusWhileRequested,
        autoInit};
      `REG_STATUS: readMux = {23'h000000, status};
      `REG_RESULT: readMux = {24'h000000, resultCode};
      `REG_DMA_COUNT: readMux = {{(32-COUNT_W){1'b0}}, dmaCount};
      `REG_DMA_LEFT: readMux = {{(31-COUNT_W){1'b0}}, dmaRun, dmaLeft};
      default: readMapped = 1'b0;
    endcase
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readMux;
      s_axi_rresp <= readMapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // gpib_event_mask_dma_mode
`default_nettype wire

// File: gpib_event_mask_dma_mode_defs.vh
// Register map, field positions, reset values and timing counts
`ifndef GPIB_EVENT_MASK_DMA_MODE_DEFS_VH
`define GPIB_EVENT_MASK_DMA_MODE_DEFS_VH

// ==========================================================
// Register byte addresses
`define REG_BOARD 6'h00
`define REG_DISARM 6'h04
`define REG_DMA_MODE 6'h08
`define REG_STATUS 6'h0c
`define REG_RESULT 6'h10
`define REG_DMA_COUNT 6'h14
`define REG_DMA_LEFT 6'h18

// ==========================================================
// Event bit positions
`define EV_UNADDRESSED 0
`define EV_TALKER 1
`define EV_LISTENER 2
`define EV_CLEARED 3
`define EV_OWN_SRQ 4
`define EV_TRIGGERED 5
`define EV_PERIPHERAL 6
`define EV_ACTIVE_CTRL 7
`define EV_ADDR_CHANGE 8
`define EV_COUNT 9
`define EV_RESERVED_MASK 16'hfe00

// ==========================================================
// DMA mode fields
`define DMA_AUTO_BIT 0
`define DMA_DEMAND_BIT 1
`define DMA_SINGLE_BIT 2
`define DMA_MODE_RESERVED_MASK 16'hfff8
`define DMA_MODE_RESET 3'h4

// ==========================================================
// Completion codes
`define RES_OK 8'h00
`define RES_BAD_BOARD 8'h01
`define RES_RESERVED_SET 8'h02
`define RES_BOTH_MODES 8'h03

// ==========================================================
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ==========================================================
// Timing: least request gap in single mode, in ns, and in cycles at 8 ns
`define CLK_PERIOD_NS 8
`define SINGLE_GAP_NS 16
`define SINGLE_GAP_CYCLES ((`SINGLE_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: dma_host_model.sv
// Host DMA controller model that answers requests with byte moves
`timescale 1ns/10ps
`default_nettype none
module dma_host_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic dmaReq,
  input wire logic [3:0] lat,
  output logic byteTaken
);
  logic [3:0] waitCnt;
  // ==========
  // Bus grant after lat cycles, then a byte every other cycle while dmaReq is held
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitCnt <= 4'h0;
      byteTaken <= 1'b0;
    end
    else
    begin
      waitCnt <= !dmaReq ? lat : (waitCnt != 4'h0 ? waitCnt - 4'h1 : waitCnt);
      byteTaken <= dmaReq && waitCnt == 4'h0 && !byteTaken;
    end
  end
endmodule // dma_host_model
`default_nettype wire

// File: gpib_event_mask_dma_mode_monitor.sv
// Bus handshake and DMA request checks on the block's ports
`timescale 1ns/10ps
`default_nettype none
module gpib_event_mask_dma_mode_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic byteTaken,
  input wire logic dmaReq,
  input wire logic dmaDone
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Sequences
  sequence gapTwo;
    !dmaReq ##1 !dmaReq;
  endsequence
  sequence bothHeld;
    !s_axi_awready && !s_axi_wready;
  endsequence
  // ==========
  // Assertions
  chk_b_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  chk_r_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  chk_ar_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready with rvalid");
  chk_aw_refused:
    assert property (s_axi_bvalid |-> bothHeld) else $error("write taken with bvalid");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
  chk_write_answer:
    assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
      else $error("response without both items");
  chk_dma_gap:
    assert property ($fell(dmaReq) |-> gapTwo) else $error("request gap too short");
  chk_done_cause:
    assert property (dmaDone |-> $past(byteTaken)) else $error("done without a byte");
  chk_done_pulse:
    assert property (dmaDone |=> !dmaDone) else $error("done longer than a cycle");
endmodule // gpib_event_mask_dma_mode_monitor
bind gpib_event_mask_dma_mode gpib_event_mask_dma_mode_monitor mon (.mclk, .rst_n,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .byteTaken, .dmaReq, .dmaDone);
`default_nettype wire

// File: gpib_event_mask_dma_mode_test.sv
// Register, event and DMA tests for the event mask block
`timescale 1ns/10ps
`default_nettype none
`include "gpib_event_mask_dma_mode_defs.vh"
module gpib_event_mask_dma_mode_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, byteReady = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [8:0] gpibEvent = 9'h000;
  logic byteTaken, dmaReq, dmaDone, lightPenIrq, got;
  integer nErrors = 0, checked = 0, cycles = 0, nTaken = 0, nDone = 0, i;
  gpib_event_mask_dma_mode #(.BOARD_ID(2'h0), .COUNT_W(16)) dut (.mclk, .rst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .gpibEvent, .byteReady, .byteTaken, .dmaReq,
    .dmaDone, .lightPenIrq);
  dma_host_model host (.mclk, .rst_n, .dmaReq, .lat, .byteTaken);
  // ==========
  // Clock, counters and timeout
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (byteTaken)
      nTaken <= nTaken + 1;
    if (dmaDone)
      nDone <= nDone + 1;
    if (cycles == 20000)
    begin
      nErrors = nErrors + 1;
      giveVerdict;
    end
  end
  // ==========
  // Tasks
  task giveVerdict;
  begin
    $display("errors %0d checks %0d", nErrors, checked);
    if (nErrors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      nErrors = nErrors + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
  begin
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    got = 1'b0;
    while (!got)
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        got = 1'b1;
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  end
  endtask
  task rd(input logic [5:0] a);
  begin
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    got = 1'b0;
    while (!got)
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        got = 1'b1;
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  end
  endtask
  task dmaRun(input logic [31:0] mode, input integer cnt, input logic [3:0] l, input integer n);
    integer t0, d0;
  begin
    lat <= l;
    wr(`REG_DMA_MODE, mode);
    t0 = nTaken;
    d0 = nDone;
    byteReady <= 1'b1;
    wr(`REG_DMA_COUNT, cnt);
    while (nDone - d0 < n)
      @(posedge mclk);
    check(nTaken - t0, cnt * n);
    byteReady <= 1'b0;
    rd(`REG_DMA_LEFT);
    check(rv, (n == 1) ? 32'h0 : (32'h10000 | cnt));
    $display("test dma mode %0h done", mode);
  end
  endtask
  // ==========
  // Tests
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`REG_DMA_MODE);
    check(rv, 32'h4);
    rd(`REG_DISARM);
    check(rv, 32'h0);
    rd(6'h1c);
    check({rv[29:0], rsp}, {30'h0, `RESP_SLVERR});
    wr(6'h1c, 32'h1);
    check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(`REG_DISARM, 32'h200);
    rd(`REG_RESULT);
    check(rv, {24'h0, `RES_RESERVED_SET});
    wr(`REG_BOARD, 32'h1);
    wr(`REG_DISARM, 32'h1);
    rd(`REG_RESULT);
    check(rv, {24'h0, `RES_BAD_BOARD});
    wr(`REG_BOARD, 32'h0);
    rd(`REG_RESULT);
    check(rv, {24'h0, `RES_OK});
    rd(`REG_DISARM);
    check(rv, 32'h0);
    wr(`REG_DMA_MODE, 32'h6);
    rd(`REG_RESULT);
    check(rv, {24'h0, `RES_BOTH_MODES});
    rd(`REG_DMA_MODE);
    check(rv, 32'h4);
    wr(`REG_DMA_MODE, 32'h8);
    rd(`REG_RESULT);
    check(rv, {24'h0, `RES_RESERVED_SET});
    $display("test registers done");
    for (i = 0; i < 9; i = i + 1)
    begin
      wr(`REG_DISARM, 32'h1 << i);
      gpibEvent[i] <= 1'b1;
      repeat (5) @(posedge mclk);
      check({31'h0, lightPenIrq}, 32'h0);
      rd(`REG_STATUS);
      check(rv, 32'h1 << i);
      wr(`REG_DISARM, 32'h0);
      check({31'h0, lightPenIrq}, 32'h1);
      wr(`REG_STATUS, 32'h1 << i);
      gpibEvent[i] <= 1'b0;
      check({31'h0, lightPenIrq}, 32'h0);
    end
    $display("test events done");
    dmaRun(32'h4, 3, 4'h3, 1);
    dmaRun(32'h2, 4, 4'h0, 1);
    dmaRun(32'h5, 2, 4'h1, 2);
    giveVerdict;
  end
endmodule // gpib_event_mask_dma_mode_test
`default_nettype wire
